// ---- include/lpm_pkg.sv ----
/*
  lpm_pkg: shared constants and types for the low-power-mode link between a
  mobile low-power DDR memory device model and its host controller.
  assumes: one 100 MHz system clock on both ends; the link clock CK is the
  system clock divided by CK_DIV and is made by the host.
*/
package lpm_pkg;

	// ==========================================================
	// clock and link geometry
	localparam int CLK_MHZ = 100;
	localparam int CLK_NS  = 10;
	localparam int CK_DIV  = 2;
	localparam int CK_NS   = CLK_NS * CK_DIV;
	localparam int ADDR_W  = 12;
	localparam int BA_W    = 2;
	localparam int NBANK   = 4;
	localparam int A10_POS = 10;

	// ==========================================================
	// command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_READ  = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_BST   = 4'h6;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_MRS   = 4'h0;

	// bank address that selects the mode and extended mode register
	localparam logic [1:0] BA_MR  = 2'h0;
	localparam logic [1:0] BA_EMR = 2'h2;
	localparam logic [11:0] MR_RST = 12'h000;

	// ==========================================================
	// timing, in ns as configured, and in CK cycles (rounded up)
	localparam int T_RCD_NS  = 18;
	localparam int T_WR_NS   = 15;
	localparam int T_RP_NS   = 18;
	localparam int T_RFC_NS  = 80;
	localparam int T_MRD_NS  = 10;
	localparam int RD_LAT    = 3;
	localparam int BURST_LEN = 4;
	localparam int T_RCD_CK  = (T_RCD_NS + CK_NS - 1) / CK_NS;
	localparam int T_WR_CK   = (T_WR_NS + CK_NS - 1) / CK_NS;
	localparam int T_RP_CK   = (T_RP_NS + CK_NS - 1) / CK_NS;
	localparam int T_RFC_CK  = (T_RFC_NS + CK_NS - 1) / CK_NS;
	localparam int T_MRD_CK  = (T_MRD_NS + CK_NS - 1) / CK_NS;
	localparam int RD_DONE_CK = RD_LAT + BURST_LEN / 2;
	localparam int WR_DONE_CK = 1 + BURST_LEN / 2 + T_WR_CK;

	// nop interval after deep sleep exit
	localparam int DSM_NOP_US  = 200;
	localparam int DSM_NOP_CYC = DSM_NOP_US * CLK_MHZ;

	// device sees CK held low this many system cycles before calling it stopped
	localparam int STOP_DET_CYC = 4;

	// ==========================================================
	// host request kinds
	typedef enum logic [3:0] {
		REQ_ACT       = 4'h0,
		REQ_READ      = 4'h1,
		REQ_WRITE     = 4'h2,
		REQ_PRE       = 4'h3,
		REQ_REF       = 4'h4,
		REQ_MRS       = 4'h5,
		REQ_DSM_ENTER = 4'h6,
		REQ_DSM_EXIT  = 4'h7,
		REQ_CLK_STOP  = 4'h8,
		REQ_CLK_RUN   = 4'h9
	} lpm_req_type;

endpackage

// ---- include/lpm_if.sv ----
/*
  lpm_if: command, clock and clock-enable pins between host and device.
  assumes: all pins are one-way, driven by the host, sampled by the device.
*/
`timescale 1ns/10ps
interface lpm_if;
	logic                       ck_p;
	logic                       ck_n;
	logic                       cke;
	logic [3:0]                 cmd;
	logic [lpm_pkg::BA_W-1:0]   ba;
	logic [lpm_pkg::ADDR_W-1:0] addr;

	modport host (output ck_p, output ck_n, output cke, output cmd, output ba, output addr);
	modport dev  (input ck_p, input ck_n, input cke, input cmd, input ba, input addr);
endinterface

// ---- design/lpm_dev.sv ----
/*
  lpm_dev: device end; decodes commands on CK rising edges, tracks open
  banks and mode registers, deep sleep mode and clock stop.
  assumes: link pins come from another timing domain and are synchronised
  here; CK is mclk divided by CK_DIV so every CK level lasts >= 1 mclk.
*/
`timescale 1ns/10ps
module lpm_dev (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// link
	lpm_if.dev                              link,
	// status
	output logic                            in_dsm_r,
	output logic                            vgen_on_r,
	output logic                            data_lost_r,
	output logic                            mr_valid_r,
	output logic [lpm_pkg::ADDR_W-1:0]      mode_reg_r,
	output logic [lpm_pkg::ADDR_W-1:0]      emode_reg_r,
	output logic [lpm_pkg::NBANK-1:0]       open_banks_r,
	output logic                            clk_stopped_r
);
	// ck_p, ck_n, cke and the four command bits, then bank and address
	localparam int PW = 7 + lpm_pkg::BA_W + lpm_pkg::ADDR_W;

	typedef enum logic [1:0] {
		DEV_INIT  = 2'h0,
		DEV_READY = 2'h1,
		DEV_DSM   = 2'h2
	} lpm_dev_type;

	// ==========================================================
	// pin synchroniser: stage 1 is read by stage 2 only
	logic [PW-1:0] s1_r, s2_r;
	logic          ck_d_r;
	logic [PW-1:0] pins;
	assign pins = {link.ck_p, link.ck_n, link.cke, link.cmd, link.ba, link.addr};

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s1_r   <= '0;
			s2_r   <= '0;
			ck_d_r <= 1'b0;
		end else begin
			s1_r   <= pins;
			s2_r   <= s1_r;
			ck_d_r <= s2_r[PW-1];
		end
	end

	logic                       ck_s, ckn_s, cke_s, rise;
	logic [3:0]                 cmd_s;
	logic [lpm_pkg::BA_W-1:0]   ba_s;
	logic [lpm_pkg::ADDR_W-1:0] addr_s;
	assign {ck_s, ckn_s, cke_s, cmd_s, ba_s, addr_s} = s2_r;
	assign rise = ck_s & ~ck_d_r;

	// ==========================================================
	// state
	lpm_dev_type                state_r, state_nxt;
	logic                       in_dsm_nxt, vgen_on_nxt, data_lost_nxt, mr_valid_nxt;
	logic                       mr_set_r, mr_set_nxt, emr_set_r, emr_set_nxt;
	logic [lpm_pkg::ADDR_W-1:0] mode_reg_nxt, emode_reg_nxt;
	logic [lpm_pkg::NBANK-1:0]  open_banks_nxt;
	logic                       clk_stopped_nxt;
	logic [2:0]                 stop_cnt_r, stop_cnt_nxt;

	always_comb begin
		state_nxt       = state_r;
		vgen_on_nxt     = vgen_on_r;
		data_lost_nxt   = data_lost_r;
		mr_set_nxt      = mr_set_r;
		emr_set_nxt     = emr_set_r;
		mode_reg_nxt    = mode_reg_r;
		emode_reg_nxt   = emode_reg_r;
		open_banks_nxt  = open_banks_r;
		stop_cnt_nxt    = stop_cnt_r;
		clk_stopped_nxt = clk_stopped_r;
		if (rise) begin
			stop_cnt_nxt    = 3'h0;
			clk_stopped_nxt = 1'b0;
			if (state_r == DEV_DSM) begin
				// cke stays low throughout; first high sample ends the mode
				if (cke_s) begin
					state_nxt   = DEV_INIT;
					vgen_on_nxt = 1'b1;
				end
			end else if (!cke_s && cmd_s == lpm_pkg::CMD_BST) begin
				state_nxt      = DEV_DSM;
				vgen_on_nxt    = 1'b0;
				data_lost_nxt  = 1'b1;
				open_banks_nxt = '0;
				mr_set_nxt     = 1'b0;
				emr_set_nxt    = 1'b0;
				mode_reg_nxt   = lpm_pkg::MR_RST;
				emode_reg_nxt  = lpm_pkg::MR_RST;
			end else if (cke_s) begin
				unique case (cmd_s)
					lpm_pkg::CMD_ACT: open_banks_nxt[ba_s] = 1'b1;
					lpm_pkg::CMD_PRE: begin
						if (addr_s[lpm_pkg::A10_POS])
							open_banks_nxt = '0;
						else
							open_banks_nxt[ba_s] = 1'b0;
					end
					lpm_pkg::CMD_MRS: begin
						if (ba_s == lpm_pkg::BA_MR) begin
							mode_reg_nxt = addr_s;
							mr_set_nxt   = 1'b1;
						end else if (ba_s == lpm_pkg::BA_EMR) begin
							emode_reg_nxt = addr_s;
							emr_set_nxt   = 1'b1;
						end
					end
					default: ;
				endcase
				if (state_r == DEV_INIT && mr_set_nxt && emr_set_nxt)
					state_nxt = DEV_READY;
			end
		end else if (state_r != DEV_DSM && cke_s && !ck_s && ckn_s) begin
			// clock held low/high with cke high: state simply freezes
			if (stop_cnt_r != 3'(lpm_pkg::STOP_DET_CYC))
				stop_cnt_nxt = stop_cnt_r + 3'h1;
			else
				clk_stopped_nxt = 1'b1;
		end
		in_dsm_nxt   = (state_nxt == DEV_DSM);
		mr_valid_nxt = mr_set_nxt & emr_set_nxt;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_r       <= DEV_INIT;
			in_dsm_r      <= 1'b0;
			vgen_on_r     <= 1'b1;
			data_lost_r   <= 1'b0;
			mr_valid_r    <= 1'b0;
			mr_set_r      <= 1'b0;
			emr_set_r     <= 1'b0;
			mode_reg_r    <= lpm_pkg::MR_RST;
			emode_reg_r   <= lpm_pkg::MR_RST;
			open_banks_r  <= '0;
			stop_cnt_r    <= 3'h0;
			clk_stopped_r <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			in_dsm_r      <= in_dsm_nxt;
			vgen_on_r     <= vgen_on_nxt;
			data_lost_r   <= data_lost_nxt;
			mr_valid_r    <= mr_valid_nxt;
			mr_set_r      <= mr_set_nxt;
			emr_set_r     <= emr_set_nxt;
			mode_reg_r    <= mode_reg_nxt;
			emode_reg_r   <= emode_reg_nxt;
			open_banks_r  <= open_banks_nxt;
			stop_cnt_r    <= stop_cnt_nxt;
			clk_stopped_r <= clk_stopped_nxt;
		end
	end
endmodule

// ---- design/lpm_host.sv ----
/*
  lpm_host: host controller end; makes CK from mclk, issues commands,
  waits out command timing before clock stop, drives deep sleep entry/exit.
  assumes: a user side that offers one request at a time with valid/ready.
*/
`timescale 1ns/10ps
module lpm_host #(
	parameter int DSM_NOP_CYC = lpm_pkg::DSM_NOP_CYC
) (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// user request
	input  wire logic                       req_valid,
	input  wire lpm_pkg::lpm_req_type       req_kind,
	input  wire logic [lpm_pkg::BA_W-1:0]   req_ba,
	input  wire logic [lpm_pkg::ADDR_W-1:0] req_addr,
	output logic                            req_ready_r,
	output logic                            req_err_r,
	// status
	output logic                            in_dsm_r,
	output logic                            clk_stopped_r,
	output logic                            init_needed_r,
	// link
	lpm_if.host                             link
);
	typedef enum logic [2:0] {
		H_RUN     = 3'h0,
		H_STOP    = 3'h1,
		H_RESTART = 3'h2,
		H_DSM     = 3'h3,
		H_DSM_NOP = 3'h4
	} lpm_hst_type;

	// ==========================================================
	// registers
	lpm_hst_type                state_r, state_nxt;
	logic                       ck_p_r, ck_p_nxt;
	logic                       cke_r, cke_nxt;
	logic [3:0]                 cmd_r, cmd_nxt;
	logic [lpm_pkg::BA_W-1:0]   ba_r, ba_nxt;
	logic [lpm_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic [lpm_pkg::NBANK-1:0]  open_r, open_nxt;
	logic [4:0]                 busy_r, busy_nxt;
	logic [15:0]                dsm_cnt_r, dsm_cnt_nxt;
	logic                       mr_done_r, mr_done_nxt, emr_done_r, emr_done_nxt;
	logic                       ready_nxt, err_nxt, init_nxt;
	logic                       ck_n_r, ck_n_nxt, dsm_nxt, stop_nxt;
	logic                       take, tick;

	assign link.ck_p = ck_p_r;
	assign link.ck_n = ck_n_r;
	assign link.cke  = cke_r;
	assign link.cmd  = cmd_r;
	assign link.ba   = ba_r;
	assign link.addr = addr_r;

	// ck falls next cycle, so a command set now is steady at the next rising edge
	assign tick = ck_p_r;
	assign take = req_valid & req_ready_r;

	// ==========================================================
	// next state
	always_comb begin
		state_nxt    = state_r;
		cke_nxt      = cke_r;
		cmd_nxt      = cmd_r;
		ba_nxt       = ba_r;
		addr_nxt     = addr_r;
		open_nxt     = open_r;
		busy_nxt     = busy_r;
		dsm_cnt_nxt  = dsm_cnt_r;
		mr_done_nxt  = mr_done_r;
		emr_done_nxt = emr_done_r;
		err_nxt      = 1'b0;
		ck_p_nxt     = ~ck_p_r;
		if (tick) begin
			cmd_nxt = lpm_pkg::CMD_NOP;
			if (busy_r != 5'h0)
				busy_nxt = busy_r - 5'h1;
		end
		unique case (state_r)
			H_RUN: begin
				if (take) begin
					ba_nxt   = req_ba;
					addr_nxt = req_addr;
					unique case (req_kind)
						lpm_pkg::REQ_ACT: begin
							if (init_needed_r || open_r[req_ba])
								err_nxt = 1'b1;
							else begin
								cmd_nxt          = lpm_pkg::CMD_ACT;
								open_nxt[req_ba] = 1'b1;
								busy_nxt         = 5'(lpm_pkg::T_RCD_CK);
							end
						end
						lpm_pkg::REQ_READ, lpm_pkg::REQ_WRITE: begin
							if (init_needed_r || !open_r[req_ba])
								err_nxt = 1'b1;
							else if (req_kind == lpm_pkg::REQ_READ) begin
								cmd_nxt  = lpm_pkg::CMD_READ;
								busy_nxt = 5'(lpm_pkg::RD_DONE_CK);
							end else begin
								cmd_nxt  = lpm_pkg::CMD_WRITE;
								busy_nxt = 5'(lpm_pkg::WR_DONE_CK);
							end
						end
						lpm_pkg::REQ_PRE: begin
							cmd_nxt = lpm_pkg::CMD_PRE;
							if (req_addr[lpm_pkg::A10_POS])
								open_nxt = '0;
							else
								open_nxt[req_ba] = 1'b0;
							busy_nxt = 5'(lpm_pkg::T_RP_CK);
						end
						lpm_pkg::REQ_REF, lpm_pkg::REQ_MRS: begin
							if (open_r != '0)
								err_nxt = 1'b1;
							else if (req_kind == lpm_pkg::REQ_REF) begin
								cmd_nxt  = lpm_pkg::CMD_REF;
								busy_nxt = 5'(lpm_pkg::T_RFC_CK);
							end else begin
								cmd_nxt  = lpm_pkg::CMD_MRS;
								busy_nxt = 5'(lpm_pkg::T_MRD_CK);
								if (req_ba == lpm_pkg::BA_MR)
									mr_done_nxt = 1'b1;
								if (req_ba == lpm_pkg::BA_EMR)
									emr_done_nxt = 1'b1;
							end
						end
						lpm_pkg::REQ_DSM_ENTER: begin
							// ready already implies no command still running
							if (open_r != '0)
								err_nxt = 1'b1;
							else begin
								cmd_nxt      = lpm_pkg::CMD_BST;
								cke_nxt      = 1'b0;
								mr_done_nxt  = 1'b0;
								emr_done_nxt = 1'b0;
								state_nxt    = H_DSM;
							end
						end
						lpm_pkg::REQ_CLK_STOP: begin
							state_nxt = H_STOP;
							ck_p_nxt  = 1'b0;
						end
						default: err_nxt = 1'b1;
					endcase
				end
			end
			H_STOP: begin
				ck_p_nxt = 1'b0;
				if (take) begin
					if (req_kind == lpm_pkg::REQ_CLK_RUN) begin
						state_nxt = H_RESTART;
						ck_p_nxt  = 1'b1;
					end else
						err_nxt = 1'b1;
				end
			end
			H_RESTART: begin
				// the nop set before the stop is registered on the restart edge
				if (tick)
					state_nxt = H_RUN;
			end
			H_DSM: begin
				if (take) begin
					if (req_kind == lpm_pkg::REQ_DSM_EXIT) begin
						cke_nxt     = 1'b1;
						dsm_cnt_nxt = 16'(DSM_NOP_CYC);
						state_nxt   = H_DSM_NOP;
					end else
						err_nxt = 1'b1;
				end
			end
			H_DSM_NOP: begin
				if (dsm_cnt_r != 16'h0)
					dsm_cnt_nxt = dsm_cnt_r - 16'h1;
				else if (tick)
					state_nxt = H_RUN;
			end
			default: state_nxt = H_RUN;
		endcase
		init_nxt  = ~(mr_done_nxt & emr_done_nxt);
		// own flop for the complement so both halves switch on one edge
		ck_n_nxt  = ~ck_p_nxt;
		dsm_nxt   = (state_nxt == H_DSM || state_nxt == H_DSM_NOP);
		stop_nxt  = (state_nxt == H_STOP);
		ready_nxt = (state_nxt == H_STOP) ||
		            (ck_p_nxt && busy_nxt == 5'h0 &&
		             (state_nxt == H_RUN || state_nxt == H_DSM));
	end

	// ==========================================================
	// registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_r       <= H_RUN;
			ck_p_r        <= 1'b0;
			ck_n_r        <= 1'b1;
			cke_r         <= 1'b1;
			cmd_r         <= lpm_pkg::CMD_NOP;
			ba_r          <= '0;
			addr_r        <= '0;
			open_r        <= '0;
			busy_r        <= 5'h0;
			dsm_cnt_r     <= 16'h0;
			mr_done_r     <= 1'b0;
			emr_done_r    <= 1'b0;
			req_ready_r   <= 1'b0;
			req_err_r     <= 1'b0;
			in_dsm_r      <= 1'b0;
			clk_stopped_r <= 1'b0;
			init_needed_r <= 1'b1;
		end else begin
			state_r       <= state_nxt;
			ck_p_r        <= ck_p_nxt;
			ck_n_r        <= ck_n_nxt;
			cke_r         <= cke_nxt;
			cmd_r         <= cmd_nxt;
			ba_r          <= ba_nxt;
			addr_r        <= addr_nxt;
			open_r        <= open_nxt;
			busy_r        <= busy_nxt;
			dsm_cnt_r     <= dsm_cnt_nxt;
			mr_done_r     <= mr_done_nxt;
			emr_done_r    <= emr_done_nxt;
			req_ready_r   <= ready_nxt;
			req_err_r     <= err_nxt;
			in_dsm_r      <= dsm_nxt;
			clk_stopped_r <= stop_nxt;
			init_needed_r <= init_nxt;
		end
	end
endmodule

// ---- dv/lpm_props.sv ----
/*
  lpm_props: assertions on the link pins between host and device.
  assumes: instantiated beside the lpm_if instance; one mclk domain.
*/
`timescale 1ns/10ps
module lpm_props #(
	parameter int DSM_NOP_CYC = 40
) (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// link
	input  wire logic                       ck_p,
	input  wire logic                       ck_n,
	input  wire logic                       cke,
	input  wire logic [3:0]                 cmd,
	input  wire logic [lpm_pkg::BA_W-1:0]   ba,
	input  wire logic [lpm_pkg::ADDR_W-1:0] addr
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// ==========================================================
	// helper state: open banks and mclk since the last command edge
	logic       ck_q_r;
	logic       cke_q_r;
	logic [3:0] open_r;
	int         since_r;
	int         need_r;
	int         exit_cnt_r;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ck_q_r <= 1'b0;
			cke_q_r <= 1'b1;
			open_r <= 4'h0;
			since_r <= 0;
			need_r <= 0;
			exit_cnt_r <= 0;
		end else begin
			ck_q_r <= ck_p;
			cke_q_r <= cke;
			if (since_r < 1000)
				since_r <= since_r + 1;
			if (cke && !cke_q_r)
				exit_cnt_r <= 1;
			else if (exit_cnt_r != 0 && exit_cnt_r < DSM_NOP_CYC)
				exit_cnt_r <= exit_cnt_r + 1;
			else
				exit_cnt_r <= 0;
			if (ck_p && !ck_q_r && cke && cmd != lpm_pkg::CMD_NOP) begin
				since_r <= 1;
				case (cmd)
					lpm_pkg::CMD_ACT: begin
						need_r <= lpm_pkg::T_RCD_CK * lpm_pkg::CK_DIV;
						open_r[ba] <= 1'b1;
					end
					lpm_pkg::CMD_READ: need_r <= lpm_pkg::RD_DONE_CK * lpm_pkg::CK_DIV;
					lpm_pkg::CMD_WRITE: need_r <= lpm_pkg::WR_DONE_CK * lpm_pkg::CK_DIV;
					lpm_pkg::CMD_PRE: begin
						need_r <= lpm_pkg::T_RP_CK * lpm_pkg::CK_DIV;
						if (addr[lpm_pkg::A10_POS])
							open_r <= 4'h0;
						else
							open_r[ba] <= 1'b0;
					end
					lpm_pkg::CMD_REF: need_r <= lpm_pkg::T_RFC_CK * lpm_pkg::CK_DIV;
					lpm_pkg::CMD_MRS: need_r <= lpm_pkg::T_MRD_CK * lpm_pkg::CK_DIV;
					default: need_r <= 0;
				endcase
			end
		end
	end

	// ==========================================================
	// ck low on two edges in a row can only mean a stopped clock
	a_ck_complement: assert property (ck_n == !ck_p)
		else $error("link clock halves not complementary");
	a_stop_cke_high: assert property ((!ck_p && !ck_q_r) |-> cke)
		else $error("clock stopped with cke low");
	a_stop_when_done: assert property ((!ck_p && !ck_q_r) |-> since_r >= need_r)
		else $error("clock stopped before last command completed");
	a_dsm_uses_bst: assert property ($fell(cke) |-> cmd == lpm_pkg::CMD_BST)
		else $error("cke fell without burst terminate");
	a_dsm_banks_idle: assert property ($fell(cke) |-> open_r == 4'h0)
		else $error("deep sleep entered with a bank open");
	a_cke_held_low: assert property ($fell(cke) |-> !cke [*8])
		else $error("cke not held low in deep sleep");
	a_exit_clk_runs: assert property ($rose(cke) |-> ck_p != $past(ck_p))
		else $error("cke raised on a still clock");
	a_exit_nop_wait: assert property (exit_cnt_r != 0 |-> cmd == lpm_pkg::CMD_NOP)
		else $error("command during deep sleep exit wait");
	a_restart_nop: assert property (($rose(ck_p) && !$past(ck_p, 2)) |-> cmd == lpm_pkg::CMD_NOP)
		else $error("clock restart without nop");
	a_cmd_one_period: assert property (($changed(cmd) && cmd != lpm_pkg::CMD_NOP && cke)
		|=> $stable(cmd) ##1 cmd == lpm_pkg::CMD_NOP)
		else $error("command not followed by nop");
endmodule

// ---- dv/lpm_low_power_modes_bench.sv ----
/*
  lpm_low_power_modes_bench: host and device joined by lpm_if; user requests
  drive the host, error pulses are scored from a queue, device status read.
  assumes: 100 MHz mclk; deep sleep nop wait shortened to 40 mclk.
*/
`timescale 1ns/10ps
module lpm_low_power_modes_bench;
	localparam int NOP_CYC = 40;
	logic                       mclk;
	logic                       resetn;
	logic                       req_valid;
	lpm_pkg::lpm_req_type       req_kind;
	logic [lpm_pkg::BA_W-1:0]   req_ba;
	logic [lpm_pkg::ADDR_W-1:0] req_addr;
	logic                       h_ready, h_err, h_in_dsm, h_clk_stopped, h_init_needed;
	logic                       d_in_dsm, d_vgen_on, d_data_lost, d_mr_valid, d_clk_stopped;
	logic [lpm_pkg::ADDR_W-1:0] d_mode_reg, d_emode_reg, mr, emr;
	logic [3:0]                 d_open_banks;
	logic [1:0]                 b;
	logic                       exp_q[$];
	int                         fails, n_tests, seed, i;
	lpm_pkg::lpm_req_type       ks[6];

	lpm_if lnk ();
	lpm_host #(.DSM_NOP_CYC(NOP_CYC)) i_lpm_host (.mclk(mclk), .resetn(resetn),
		.req_valid(req_valid), .req_kind(req_kind), .req_ba(req_ba), .req_addr(req_addr),
		.req_ready_r(h_ready), .req_err_r(h_err), .in_dsm_r(h_in_dsm),
		.clk_stopped_r(h_clk_stopped), .init_needed_r(h_init_needed), .link(lnk.host));
	lpm_dev i_lpm_dev (.mclk(mclk), .resetn(resetn), .link(lnk.dev), .in_dsm_r(d_in_dsm),
		.vgen_on_r(d_vgen_on), .data_lost_r(d_data_lost), .mr_valid_r(d_mr_valid),
		.mode_reg_r(d_mode_reg), .emode_reg_r(d_emode_reg), .open_banks_r(d_open_banks),
		.clk_stopped_r(d_clk_stopped));
	lpm_props #(.DSM_NOP_CYC(NOP_CYC)) i_lpm_props (.mclk(mclk), .resetn(resetn),
		.ck_p(lnk.ck_p), .ck_n(lnk.ck_n), .cke(lnk.cke), .cmd(lnk.cmd), .ba(lnk.ba),
		.addr(lnk.addr));

	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// holds the request until taken, then leaves room for the error pulse
	task automatic do_req(input lpm_pkg::lpm_req_type k, input logic [1:0] ba,
			input logic [11:0] a, input logic e);
		int n;
		exp_q.push_back(e);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_kind <= k;
		req_ba <= ba;
		req_addr <= a;
		for (n = 0; n < 300; n++) begin
			@(posedge mclk);
			if (h_ready === 1'b1)
				break;
		end
		if (n == 300)
			fails++;
		req_valid <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic init_seq();
		mr = 12'($random(seed));
		emr = 12'($random(seed));
		do_req(lpm_pkg::REQ_PRE, 2'h0, 12'h400, 1'b0);
		do_req(lpm_pkg::REQ_REF, 2'h0, 12'h000, 1'b0);
		do_req(lpm_pkg::REQ_REF, 2'h0, 12'h000, 1'b0);
		do_req(lpm_pkg::REQ_MRS, lpm_pkg::BA_MR, mr, 1'b0);
		do_req(lpm_pkg::REQ_MRS, lpm_pkg::BA_EMR, emr, 1'b0);
		repeat (8) @(posedge mclk);
		check(h_init_needed, 0);
		check(d_mode_reg, mr);
		check(d_emode_reg, emr);
		check(d_mr_valid, 1);
	endtask

	// ==========================================================
	// clock, watchdog, error-pulse monitor
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		#100000;
		fails++;
		give_verdict();
	end

	initial begin
		logic e;
		forever begin
			@(posedge mclk);
			if (req_valid === 1'b1 && h_ready === 1'b1) begin
				@(posedge mclk);
				e = h_err;
				@(posedge mclk);
				e = e | h_err;
				check(e, exp_q.pop_front());
			end
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h05984BF3;
		resetn = 1'b0;
		req_valid = 1'b0;
		req_kind = lpm_pkg::REQ_ACT;
		req_ba = 2'h0;
		req_addr = 12'h000;
		ks = '{lpm_pkg::REQ_ACT, lpm_pkg::REQ_READ, lpm_pkg::REQ_WRITE,
			lpm_pkg::REQ_PRE, lpm_pkg::REQ_REF, lpm_pkg::REQ_MRS};
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		check(h_init_needed, 1);
		check(d_vgen_on, 1);
		do_req(lpm_pkg::REQ_ACT, 2'h1, 12'h000, 1'b1);
		init_seq();
		// every access kind, each followed by a clock stop and restart
		b = 2'($random(seed));
		for (i = 0; i < 6; i++) begin
			do_req(ks[i], b, (ks[i] == lpm_pkg::REQ_MRS) ? mr : 12'h000, 1'b0);
			do_req(lpm_pkg::REQ_CLK_STOP, 2'h0, 12'h000, 1'b0);
			repeat (10) @(posedge mclk);
			check(h_clk_stopped, 1);
			check(d_clk_stopped, 1);
			check(d_open_banks, (i < 3) ? (4'h1 << b) : 4'h0);
			if (i == 1)
				do_req(lpm_pkg::REQ_READ, b, 12'h000, 1'b1);
			do_req(lpm_pkg::REQ_CLK_RUN, 2'h0, 12'h000, 1'b0);
			repeat (4) @(posedge mclk);
			check(h_clk_stopped, 0);
			check(d_clk_stopped, 0);
		end
		// deep sleep: refused with a bank open, then entered and left
		do_req(lpm_pkg::REQ_ACT, b, 12'h000, 1'b0);
		do_req(lpm_pkg::REQ_DSM_ENTER, 2'h0, 12'h000, 1'b1);
		do_req(lpm_pkg::REQ_PRE, b, 12'h000, 1'b0);
		do_req(lpm_pkg::REQ_DSM_ENTER, 2'h0, 12'h000, 1'b0);
		repeat (8) @(posedge mclk);
		check(h_in_dsm, 1);
		check(d_in_dsm, 1);
		check(d_vgen_on, 0);
		check(d_data_lost, 1);
		check(d_mode_reg, 0);
		check(d_emode_reg, 0);
		check(d_mr_valid, 0);
		do_req(lpm_pkg::REQ_ACT, b, 12'h000, 1'b1);
		repeat (12) @(posedge mclk);
		do_req(lpm_pkg::REQ_DSM_EXIT, 2'h0, 12'h000, 1'b0);
		do_req(lpm_pkg::REQ_ACT, b, 12'h000, 1'b1);
		check(h_in_dsm, 0);
		check(d_in_dsm, 0);
		check(d_vgen_on, 1);
		check(d_data_lost, 1);
		check(h_init_needed, 1);
		init_seq();
		do_req(lpm_pkg::REQ_ACT, b, 12'h000, 1'b0);
		do_req(lpm_pkg::REQ_READ, b, 12'h000, 1'b0);
		repeat (10) @(posedge mclk);
		give_verdict();
	end
endmodule
